// ==== sim/motion_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module motion_host_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       reg_rvalid,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_rd,
  output logic [6:0]      reg_addr,
  output logic [2:0][7:0] got,
  output logic            done
);
  logic       busy_r;
  logic [1:0] step_r;
  // status, then x, then y, each after the previous answer
  always_ff @(posedge clk) begin
    reg_rd <= 1'b0;
    done   <= 1'b0;
    if (sys_rst) begin
      busy_r   <= 1'b0;
      reg_addr <= 7'h00;
    end else if (start) begin
      busy_r   <= 1'b1;
      step_r   <= 2'd0;
      reg_rd   <= 1'b1;
      reg_addr <= 7'h02;
    end else if (busy_r && reg_rvalid) begin
      got[step_r] <= reg_rdata;
      if (step_r == 2'd2) begin
        busy_r <= 1'b0;
        done   <= 1'b1;
      end else begin
        step_r   <= step_r + 2'd1;
        reg_rd   <= 1'b1;
        reg_addr <= reg_addr + 7'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/motion_report_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module motion_report_checker
  import motion_report_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5a  // arbitrary value
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              reg_rd,
  input wire logic              reg_wr,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0]        reg_rdata,
  input wire logic              reg_rvalid,
  input wire motion_sample_t    motion_in,
  input wire logic              counts_per_inch_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rd_st, rd_x, rd_y, x_seen_r, y_seen_r;
  // decode of taken reads
  assign rd_st = reg_rd && reg_addr == ADDR_MOTION_STATUS;
  assign rd_x  = reg_rd && reg_addr == ADDR_X_DISP;
  assign rd_y  = reg_rd && reg_addr == ADDR_Y_DISP;
  // displacement read once since last status read
  always_ff @(posedge clk) begin
    if (sys_rst || rd_st) begin
      x_seen_r <= 1'b0;
      y_seen_r <= 1'b0;
    end else begin
      x_seen_r <= x_seen_r | rd_x;
      y_seen_r <= y_seen_r | rd_y;
    end
  end
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_revision_code: assert property (reg_rd && reg_addr == ADDR_CHIP_REVISION |=>
    reg_rdata == REVISION_CODE) else $error("revision wrong");
  chk_cpi_bit: assert property (rd_st |=>
    reg_rdata[CPI_SELECT_BIT] == $past(counts_per_inch_select)) else $error("cpi bit wrong");
  chk_squal_cap: assert property (reg_rd && reg_addr == ADDR_SURF_QUALITY |=>
    reg_rdata <= SURF_QUALITY_MAX) else $error("quality above cap");
  chk_x_read_clear: assert property (rd_x && x_seen_r |=> reg_rdata == 8'h00)
    else $error("x not cleared");
  chk_y_read_clear: assert property (rd_y && y_seen_r |=> reg_rdata == 8'h00)
    else $error("y not cleared");
  chk_clear_motion: assert property (reg_wr && reg_addr == ADDR_MOTION_CLEAR &&
    !motion_in.valid ##1 rd_st && !motion_in.valid |=> !reg_rdata[MOVED_BIT])
    else $error("motion kept after clear");
  chk_report_range: assert property (rd_x || rd_y |=> reg_rdata != 8'h80)
    else $error("report beyond full scale");
endmodule
bind motion_report_registers motion_report_checker #(.REVISION_CODE(REVISION_CODE))
  i_motion_report_checker (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .motion_in(motion_in), .counts_per_inch_select(counts_per_inch_select));
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  import motion_report_pkg::*;
  typedef struct packed {logic [9:0] f; logic [15:0] p; logic [7:0] sq, ps;} row_t;
  localparam logic [7:0] REV = 8'h3c;  // arbitrary value
  logic           clk, sys_rst, tb_rd, reg_wr, cpi, pd, start, h_rd, h_done, reg_rvalid;
  logic [6:0]     tb_addr, h_addr;
  logic [7:0]     wdata, reg_rdata, st, x, y, d;
  logic [2:0][7:0] got;
  motion_sample_t moved_flag;
  frame_stats_t   fr;
  int             n_errors, samples_checked, n, k, a;
  row_t rows [3] = '{'{10'h3ff, 16'hffff, 8'ha9, 8'hff}, '{10'h0a7, 16'h1234, 8'h29, 8'h12},
                     '{10'h2a4, 16'h00ff, 8'ha9, 8'h00}};
  motion_report_registers #(.REVISION_CODE(REV)) i_motion_report_registers (.clk(clk),
    .sys_rst(sys_rst), .reg_rd(tb_rd | h_rd), .reg_wr(reg_wr),
    .reg_addr(h_rd ? h_addr : tb_addr), .reg_wdata(wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .motion_in(moved_flag), .frame_in(fr),
    .counts_per_inch_select(cpi), .power_down(pd));
  motion_host_model i_motion_host_model (.clk(clk), .sys_rst(sys_rst), .start(start),
    .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata), .reg_rd(h_rd), .reg_addr(h_addr),
    .got(got), .done(h_done));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait on the read answer or on the host model's done pulse
  task automatic wait_hi(input bit for_host);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while ((for_host ? h_done : reg_rvalid) !== 1'b1 && i < 20);
    if ((for_host ? h_done : reg_rvalid) === 1'b1) @(posedge clk);
    else begin n_errors++; print_verdict(); end
  endtask
  task automatic rd(input logic [6:0] ad, output logic [7:0] dv);
    tb_rd <= 1'b1;
    tb_addr <= ad;
    @(posedge clk);
    tb_rd <= 1'b0;
    wait_hi(1'b0);
    dv = reg_rdata;
  endtask
  task automatic wr(input logic [6:0] ad);
    reg_wr <= 1'b1;
    tb_addr <= ad;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic host;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_hi(1'b1);
    {y, x, st} = got;
  endtask
  task automatic mv(input logic [7:0] dx, dy, input int cnt);
    repeat (cnt) begin moved_flag <= '{1'b1, dx, dy}; @(posedge clk); end
    moved_flag.valid <= 1'b0;
  endtask
  // main sequence
  initial begin
    {sys_rst, tb_rd, reg_wr, cpi, pd, start} = 6'h20;
    {tb_addr, wdata, moved_flag, fr} = '0;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_CHIP_REVISION, d);
    `CHK("chip_revision", REV, d)
    for (a = 2; a < 8; a++) begin rd(a[6:0], d); `CHK("reset_value", 8'h00, d) end
    foreach (rows[i]) begin
      fr <= '{1'b1, rows[i].f, rows[i].p};
      @(posedge clk);
      fr.valid <= 1'b0;
      rd(ADDR_SURF_QUALITY, d);
      `CHK("surface_quality", rows[i].sq, d)
      rd(ADDR_FRAME_SUM, d);
      `CHK("frame_sum", rows[i].ps, d)
    end
    mv(8'h05, 8'hfd, 1);
    host();
    `CHK("status", 8'h80, st)
    `CHK("x_disp", 8'h05, x)
    `CHK("y_disp", 8'hfd, y)
    rd(ADDR_X_DISP, d);
    `CHK("x_again", 8'h00, d)
    rd(ADDR_Y_DISP, d);
    `CHK("y_again", 8'h00, d)
    host();
    `CHK("drained", 8'h00, st)
    mv(8'h0a, 8'h00, 1);
    rd(ADDR_MOTION_STATUS, d);
    mv(8'h07, 8'h00, 1);
    host();
    `CHK("relatched_x", 8'h07, x)
    mv(8'h09, 8'h09, 1);
    wr(ADDR_X_DISP);
    host();
    `CHK("x_after_bad_write", 8'h09, x)
    mv(8'h09, 8'h09, 1);
    wr(ADDR_MOTION_CLEAR);
    rd(ADDR_MOTION_STATUS, d);
    `CHK("status_cleared", 8'h00, d)
    mv(8'h04, 8'h04, 1);
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    rd(ADDR_MOTION_STATUS, d);
    `CHK("status_after_pd", 8'h00, d)
    for (k = 0; k < 2; k++) begin
      cpi <= k[0];
      mv(8'h7f, 8'h81, k ? 65 : 17);
      n = 0;
      do begin
        host();
        n++;
        if (n == 1) `CHK("ovf_status", {7'h48, k[0]}, st)
        if (n == 1) `CHK("x_full", 8'h7f, x)
        if (n == 1) `CHK("y_full", 8'h81, y)
        if (n == 2) `CHK("ovf_clear", 1'b0, st[4])
      end while (st[7] === 1'b1 && n < 80);
      `CHK("drain_cycles", k ? 65 : 17, n)
    end
    // mid-run reset with a latched share and pending motion
    mv(8'h05, 8'h05, 1);
    rd(ADDR_MOTION_STATUS, d);
    mv(8'h03, 8'h03, 1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_X_DISP, d);
    `CHK("x_after_reset", 8'h00, d)
    rd(ADDR_MOTION_STATUS, d);
    `CHK("status_after_reset", {7'h00, cpi}, d)
    print_verdict();
  end
endmodule
`default_nettype wire

// ==== src/motion_axis_accum.sv ====
`timescale 1ns/10ps
`default_nettype none
module motion_axis_accum
  import motion_report_pkg::*;
#(
  parameter int W = ACC_W
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              sample_valid,
  input  wire logic signed [7:0] sample,
  input  wire logic              hi_res,
  input  wire logic              take,
  input  wire logic              clear,
  output logic signed [7:0]      report,
  output logic                   moving,
  output logic                   at_full_scale,
  output logic                   clipped
);

  logic signed [W-1:0] acc_r;
  logic signed [W-1:0] acc_nxt;
  logic signed [W:0]   sum;
  logic signed [W:0]   lim;

  // ----------------------------------------------------------------
  // report share, status
  // ----------------------------------------------------------------
  assign report        = clamp_report(acc_r);
  assign moving        = (acc_r != '0);
  assign lim           = (W+1)'(axis_limit(hi_res));
  assign at_full_scale = ((W+1)'(acc_r) >= lim) || ((W+1)'(acc_r) <= -lim);

  // remove reported share or clear, then add the new frame
  always_comb begin
    sum = clear ? '0 : (W+1)'(acc_r);
    if (take && !clear)
      sum = sum - (W+1)'(report);
    if (sample_valid)
      sum = sum + (W+1)'(sample);
    clipped = 1'b0;
    acc_nxt = sum[W-1:0];
    if (sum > lim) begin
      acc_nxt = lim[W-1:0];
      clipped = 1'b1;
    end else if (sum < -lim) begin
      acc_nxt = -lim[W-1:0];
      clipped = 1'b1;
    end
  end

  // accumulator
  always_ff @(posedge clk) begin
    if (sys_rst)
      acc_r <= '0;
    else
      acc_r <= acc_nxt;
  end

endmodule
`default_nettype wire

// ==== src/motion_report_pkg.sv ====
package motion_report_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W             = 7;
  localparam logic [6:0]  ADDR_CHIP_REVISION = 7'h01;
  localparam logic [6:0]  ADDR_MOTION_STATUS = 7'h02;
  localparam logic [6:0]  ADDR_X_DISP        = 7'h03;
  localparam logic [6:0]  ADDR_Y_DISP        = 7'h04;
  localparam logic [6:0]  ADDR_SURF_QUALITY  = 7'h05;
  localparam logic [6:0]  ADDR_FRAME_SUM     = 7'h06;
  localparam logic [6:0]  ADDR_MOTION_CLEAR  = 7'h12;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          MOVED_BIT          = 7;
  localparam int          OVERFLOW_BIT       = 4;
  localparam int          CPI_SELECT_BIT     = 0;
  localparam logic [7:0]  REG_RESET          = 8'h00;
  localparam logic [7:0]  SURF_QUALITY_MAX   = 8'ha9;
  localparam int          FEATURE_W          = 10;
  localparam int          PIXEL_SUM_W        = 16;

  // ----------------------------------------------------------------
  // accumulator depth
  // ----------------------------------------------------------------
  localparam int          ACC_W              = 16;
  localparam int          FULL_SCALE         = 127;
  localparam int          DRAIN_READS_LO     = 16;
  localparam int          DRAIN_READS_HI     = 64;
  localparam logic signed [7:0] REPORT_MAX   = 8'sh7f;
  localparam logic signed [7:0] REPORT_MIN   = 8'sh81;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic signed [7:0] dx;
    logic signed [7:0] dy;
  } motion_sample_t;

  typedef struct packed {
    logic                   valid;
    logic [FEATURE_W-1:0]   feature_count;
    logic [PIXEL_SUM_W-1:0] pixel_sum;
  } frame_stats_t;

  // saturation limit of one axis for the active resolution
  function automatic logic signed [ACC_W-1:0] axis_limit(input logic hi_res);
    axis_limit = hi_res ? ACC_W'(DRAIN_READS_HI * FULL_SCALE)
                        : ACC_W'(DRAIN_READS_LO * FULL_SCALE);
  endfunction

  // portion of an accumulator one report can carry
  function automatic logic signed [7:0] clamp_report(input logic signed [ACC_W-1:0] v);
    if (v > ACC_W'(FULL_SCALE))
      clamp_report = REPORT_MAX;
    else if (v < -ACC_W'(FULL_SCALE))
      clamp_report = REPORT_MIN;
    else
      clamp_report = v[7:0];
  endfunction

endpackage

// ==== src/motion_report_registers.sv ====
`timescale 1ns/10ps
`default_nettype none
module motion_report_registers
  import motion_report_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5a  // arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              reg_rd,
  input  wire logic              reg_wr,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  output logic                   reg_rvalid,
  input  wire motion_sample_t    motion_in,
  input  wire frame_stats_t      frame_in,
  input  wire logic              counts_per_inch_select,
  input  wire logic              power_down
);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic rd_status;
  logic rd_x;
  logic rd_y;
  logic wr_clear;
  logic motion_wipe;

  // one-cycle access strobes
  assign rd_status   = reg_rd && (reg_addr == ADDR_MOTION_STATUS);
  assign rd_x        = reg_rd && (reg_addr == ADDR_X_DISP);
  assign rd_y        = reg_rd && (reg_addr == ADDR_Y_DISP);
  assign wr_clear    = reg_wr && (reg_addr == ADDR_MOTION_CLEAR);
  assign motion_wipe = wr_clear || power_down;

  // ----------------------------------------------------------------
  // accumulators
  // ----------------------------------------------------------------
  logic signed [7:0] x_report;
  logic signed [7:0] y_report;
  logic              x_moving;
  logic              y_moving;
  logic              x_full;
  logic              y_full;
  logic              x_clipped;
  logic              y_clipped;

  // x axis
  motion_axis_accum #(
    .W (ACC_W)
  ) u_x_accum (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .sample_valid  (motion_in.valid),
    .sample        (motion_in.dx),
    .hi_res        (counts_per_inch_select),
    .take          (rd_status),
    .clear         (motion_wipe),
    .report        (x_report),
    .moving        (x_moving),
    .at_full_scale (x_full),
    .clipped       (x_clipped)
  );

  // y axis
  motion_axis_accum #(
    .W (ACC_W)
  ) u_y_accum (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .sample_valid  (motion_in.valid),
    .sample        (motion_in.dy),
    .hi_res        (counts_per_inch_select),
    .take          (rd_status),
    .clear         (motion_wipe),
    .report        (y_report),
    .moving        (y_moving),
    .at_full_scale (y_full),
    .clipped       (y_clipped)
  );

  // ----------------------------------------------------------------
  // latched displacement
  // ----------------------------------------------------------------
  logic [7:0] x_disp_r;
  logic [7:0] y_disp_r;

  // status read freezes a fresh share, replacing any unread one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      x_disp_r <= REG_RESET;
    end else if (wr_clear) begin
      x_disp_r <= REG_RESET;
    end else if (rd_status) begin
      x_disp_r <= x_report;
    end else if (rd_x) begin
      x_disp_r <= REG_RESET;
    end
  end

  // same for y
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      y_disp_r <= REG_RESET;
    end else if (wr_clear) begin
      y_disp_r <= REG_RESET;
    end else if (rd_status) begin
      y_disp_r <= y_report;
    end else if (rd_y) begin
      y_disp_r <= REG_RESET;
    end
  end

  // ----------------------------------------------------------------
  // overflow flag
  // ----------------------------------------------------------------
  logic overflow_r;

  // a clip sets it and wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      overflow_r <= 1'b0;
    end else if (x_clipped || y_clipped) begin
      overflow_r <= 1'b1;
    end else if (wr_clear) begin
      overflow_r <= 1'b0;
    end else if ((rd_x || rd_y) && !x_full && !y_full) begin
      overflow_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // frame statistics
  // ----------------------------------------------------------------
  logic [7:0] surf_quality_r;
  logic [7:0] frame_sum_r;
  logic [7:0] quarter_features;

  assign quarter_features = frame_in.feature_count[FEATURE_W-1:FEATURE_W-8];

  // refresh once per frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      surf_quality_r <= REG_RESET;
      frame_sum_r    <= REG_RESET;
    end else if (frame_in.valid) begin
      surf_quality_r <= (quarter_features > SURF_QUALITY_MAX) ?
                        SURF_QUALITY_MAX : quarter_features;
      frame_sum_r    <= frame_in.pixel_sum[PIXEL_SUM_W-1:PIXEL_SUM_W-8];
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  logic [7:0] rd_mux;

  // status byte; reserved bits read zero
  always_comb begin
    status_byte                 = 8'h00;
    status_byte[MOVED_BIT]      = x_moving || y_moving;
    status_byte[OVERFLOW_BIT]   = overflow_r || x_clipped || y_clipped;
    status_byte[CPI_SELECT_BIT] = counts_per_inch_select;
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      ADDR_CHIP_REVISION: rd_mux = REVISION_CODE;
      ADDR_MOTION_STATUS: rd_mux = status_byte;
      ADDR_X_DISP:        rd_mux = x_disp_r;
      ADDR_Y_DISP:        rd_mux = y_disp_r;
      ADDR_SURF_QUALITY:  rd_mux = surf_quality_r;
      ADDR_FRAME_SUM:     rd_mux = frame_sum_r;
      default:            rd_mux = 8'h00;
    endcase
  end

  // registered answer, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata  <= REG_RESET;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire
